// ===== hdl/lcd_blank_status_gamma_power.sv
// register block: gamma table write port and lookup, power-save control, blanking status and frame-sync pin
// assumes bus strobes and timing-generator levels are synchronous to clk_sys_i
`timescale 1ns/1ps

// Overview of operation
// R1: gamma data write stores, then index advances
// R2: table keeps bits 7:6, output drops them
// R3: host writes all 64 entries per load
// R4: 5:6:5 red/blue use lower 32 entries
// R5: status bit 7 reads vertical active
// R6: vertical blank spans last to first pixel
// R7: status bit 6 reads horizontal active
// R8: horizontal blank spans line to line
// R9: status bit 5 reads both active
// R10: host never writes reserved bit 4
// R11: status bit 2 enables frame-sync pin
// R12: bits 1:0 choose frame-sync source
// R13: blanking status fields reset to zero
// R14: sleep stops pll; wait settle before memory
// R15: standby stops all but pll
// R16: bit 7 routes power-save pin
module lcd_blank_status_gamma_power #(
  parameter int unsigned SETTLE_CYCLES = 32'(lcd_regs_pkg::PLL_SETTLE_CYC) // pll settle time in clocks
) (
  input wire logic clk_sys_i, // 125 MHz system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic cs_b_i, // host chip select, active low
  input wire logic rs_i, // 0 register index cycle, 1 data cycle
  input wire logic wr_b_i, // host write strobe, active low
  input wire logic rd_b_i, // host read strobe, active low
  input wire logic [7:0] data_i, // host data in
  output logic [7:0] data_o, // host read data
  output logic data_oe_o, // high while driving the data bus
  input wire logic horizontal_active_interval_i, // timing generator: pixel inside line
  input wire logic vertical_active_interval_i, // timing generator: line inside frame
  input wire logic hsync_i, // horizontal sync level
  input wire logic vsync_i, // vertical sync level
  output logic frame_sync_output_pin_o, // frame-sync pin
  input wire logic [5:0] pix_r_i, // red pixel code
  input wire logic [5:0] pix_g_i, // green pixel code
  input wire logic [5:0] pix_b_i, // blue pixel code
  input wire logic fmt_565_i, // pixels are 5:6:5
  output logic [lcd_regs_pkg::GAMMA_OUT_W-1:0] out_r_o, // corrected red
  output logic [lcd_regs_pkg::GAMMA_OUT_W-1:0] out_g_o, // corrected green
  output logic [lcd_regs_pkg::GAMMA_OUT_W-1:0] out_b_o, // corrected blue
  input wire logic power_save_input_pin_i, // external power-save request
  output logic pll_stop_o, // stop the pll
  output logic blocks_stop_o, // stop internal blocks
  output logic mem_ready_o // memory accesses allowed
);
  import lcd_regs_pkg::*;

  logic wr_b_d_reg;
  logic rd_b_d_reg;
  logic [7:0] addr_reg;
  logic [7:0] gamma_ctrl_reg;
  logic [GAMMA_AW-1:0] gamma_index_reg;
  logic [7:0] power_save_reg;
  logic [2:0] sync_ctrl_reg;
  logic [7:0] red_tab [GAMMA_DEPTH];
  logic [7:0] green_tab [GAMMA_DEPTH];
  logic [7:0] blue_tab [GAMMA_DEPTH];
  logic wr_evt;
  logic data_wr;
  logic gamma_wr;
  logic [1:0] mode;
  logic [7:0] status_byte;
  logic sleep_req;
  logic standby_req;
  logic sleep_d_reg;
  logic [SETTLE_W-1:0] settle_reg;
  logic [SETTLE_W-1:0] settle_next;
  logic sync_src;
  logic [GAMMA_AW-1:0] r_idx;
  logic [GAMMA_AW-1:0] b_idx;
  logic [7:0] read_mux;

  // a write is taken once, on the falling edge of the sampled strobe
  assign wr_evt = ~cs_b_i & wr_b_d_reg & ~wr_b_i;
  assign data_wr = wr_evt & rs_i;
  assign gamma_wr = data_wr & (addr_reg == GAMMA_DATA_OFS);
  assign mode = gamma_ctrl_reg[GAMMA_MODE_LSB +: 2];

  // strobe history for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wr_b_d_reg <= 1'b1;
      rd_b_d_reg <= 1'b1;
    end else begin
      wr_b_d_reg <= wr_b_i;
      rd_b_d_reg <= rd_b_i;
    end
  end

  // register index cycle selects the target of later data cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      addr_reg <= 8'h00;
    end else if (wr_evt && !rs_i) begin
      addr_reg <= data_i;
    end
  end

  // plain control registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gamma_ctrl_reg <= GAMMA_CTRL_RST;
      power_save_reg <= POWER_SAVE_RST;
      sync_ctrl_reg <= SYNC_CTRL_RST; // [R13]
    end else if (data_wr) begin
      if (addr_reg == GAMMA_CTRL_OFS) begin
        gamma_ctrl_reg <= {5'h00, data_i[2:0]};
      end
      if (addr_reg == POWER_SAVE_OFS) begin
        power_save_reg <= {data_i[7], 5'h00, data_i[1:0]};
      end
      if (addr_reg == BLANK_STATUS_OFS) begin
        // status bits 7:5 are read-only; bit 4 is not stored, the host leaves it alone [R10]
        sync_ctrl_reg <= data_i[2:0]; // [R11] [R12]
      end
    end
  end

  // table index: loaded directly, then stepped after each table data write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gamma_index_reg <= GAMMA_INDEX_RST;
    end else if (data_wr && addr_reg == GAMMA_INDEX_OFS) begin
      gamma_index_reg <= data_i[GAMMA_AW-1:0];
    end else if (gamma_wr) begin
      gamma_index_reg <= gamma_index_reg + GAMMA_INDEX_STEP; // [R1] wraps at 64, so a full load [R3] ends at 0
    end
  end

  // table writes keep all eight bits, including the two unused top bits
  always_ff @(posedge clk_sys_i) begin
    if (gamma_wr) begin
      if (mode == MODE_ALL || mode == MODE_RED) begin
        red_tab[gamma_index_reg] <= data_i; // [R1] [R2]
      end
      if (mode == MODE_ALL || mode == MODE_GREEN) begin
        green_tab[gamma_index_reg] <= data_i; // [R1] [R2]
      end
      if (mode == MODE_ALL || mode == MODE_BLUE) begin
        blue_tab[gamma_index_reg] <= data_i; // [R1] [R2]
      end
    end
  end

  // 5:6:5 red and blue have five bits, so only the lower half of their tables is reached
  assign r_idx = fmt_565_i ? {1'b0, pix_r_i[4:0]} : pix_r_i; // [R4]
  assign b_idx = fmt_565_i ? {1'b0, pix_b_i[4:0]} : pix_b_i; // [R4]

  // panel path: table lookup, or bypass with msb copied into the new lsb for 5-bit channels
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      out_r_o <= '0;
      out_g_o <= '0;
      out_b_o <= '0;
    end else if (gamma_ctrl_reg[GAMMA_EN_BIT]) begin
      out_r_o <= red_tab[r_idx][GAMMA_OUT_W-1:0]; // [R2]
      out_g_o <= green_tab[pix_g_i][GAMMA_OUT_W-1:0]; // [R2]
      out_b_o <= blue_tab[b_idx][GAMMA_OUT_W-1:0]; // [R2]
    end else begin
      out_r_o <= fmt_565_i ? {pix_r_i[4:0], pix_r_i[4]} : pix_r_i;
      out_g_o <= pix_g_i;
      out_b_o <= fmt_565_i ? {pix_b_i[4:0], pix_b_i[4]} : pix_b_i;
    end
  end

  // status reads straight from the timing levels; blank spans end-of-line/frame to first pixel
  assign status_byte = {vertical_active_interval_i, // [R5] [R6]
                        horizontal_active_interval_i, // [R7] [R8]
                        vertical_active_interval_i & horizontal_active_interval_i, // [R9]
                        2'b00, sync_ctrl_reg};

  // read data mux; unmapped offsets read as zero
  always_comb begin
    read_mux = 8'h00;
    case (addr_reg)
      GAMMA_CTRL_OFS: read_mux = gamma_ctrl_reg;
      GAMMA_INDEX_OFS: read_mux = {2'b00, gamma_index_reg};
      GAMMA_DATA_OFS: begin
        case (mode)
          MODE_GREEN: read_mux = green_tab[gamma_index_reg];
          MODE_BLUE: read_mux = blue_tab[gamma_index_reg];
          default: read_mux = red_tab[gamma_index_reg];
        endcase
      end
      POWER_SAVE_OFS: read_mux = power_save_reg;
      BLANK_STATUS_OFS: read_mux = status_byte;
      default: read_mux = 8'h00;
    endcase
  end

  // read data is captured as the strobe falls and held until it rises
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      if (!cs_b_i && rd_b_d_reg && !rd_b_i) begin
        data_o <= rs_i ? read_mux : addr_reg;
      end
      data_oe_o <= ~cs_b_i & ~rd_b_i;
    end
  end

  // frame-sync source; blank levels are high during the non-display periods
  always_comb begin
    case (sync_ctrl_reg[BS_SEL_LSB +: 2])
      SYNC_SEL_HBLANK: sync_src = ~horizontal_active_interval_i; // [R12]
      SYNC_SEL_VBLANK: sync_src = ~vertical_active_interval_i; // [R12]
      SYNC_SEL_SYNCS: sync_src = hsync_i | vsync_i; // [R12]
      default: sync_src = 1'b0; // reserved code keeps the pin low
    endcase
  end

  // pin low while disabled
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      frame_sync_output_pin_o <= 1'b0;
    end else begin
      frame_sync_output_pin_o <= sync_ctrl_reg[BS_SYNC_EN_BIT] & sync_src; // [R11]
    end
  end

  // the external pin adds to whichever mode bit 7 points it at
  assign sleep_req = power_save_reg[PS_SLEEP_BIT] |
                     (power_save_input_pin_i & ~power_save_reg[PS_PIN_FUNC_BIT]); // [R16]
  assign standby_req = power_save_reg[PS_STANDBY_BIT] |
                       (power_save_input_pin_i & power_save_reg[PS_PIN_FUNC_BIT]); // [R16]

  // settle counter restarts on every sleep exit; memory waits for it to run out
  always_comb begin
    settle_next = settle_reg;
    if (sleep_req) begin
      settle_next = '0;
    end else if (sleep_d_reg) begin
      settle_next = SETTLE_CYCLES[SETTLE_W-1:0]; // [R14]
    end else if (settle_reg != '0) begin
      settle_next = settle_reg - 1'b1;
    end
  end

  // power outputs; standby leaves the pll alone so memory comes back at once
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sleep_d_reg <= 1'b0;
      settle_reg <= '0;
      pll_stop_o <= 1'b0;
      blocks_stop_o <= 1'b0;
      mem_ready_o <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_req;
      settle_reg <= settle_next;
      pll_stop_o <= sleep_req; // [R14]
      blocks_stop_o <= sleep_req | standby_req; // [R14] [R15]
      mem_ready_o <= ~sleep_req & ~standby_req & ~sleep_d_reg & (settle_next == '0); // [R14] [R15]
    end
  end
endmodule : lcd_blank_status_gamma_power

// ===== hdl/lcd_regs_pkg.sv
// constants for the blanking status, gamma table port and power-save register block
// assumes a 125 MHz system clock and an 8-bit parallel host bus with register-index and data cycles
package lcd_regs_pkg;
  // register offsets, as set by a register-index write
  localparam logic [7:0] GAMMA_CTRL_OFS = 8'h50;
  localparam logic [7:0] GAMMA_INDEX_OFS = 8'h52;
  localparam logic [7:0] GAMMA_DATA_OFS = 8'h54;
  localparam logic [7:0] POWER_SAVE_OFS = 8'h56;
  localparam logic [7:0] BLANK_STATUS_OFS = 8'h58;
  // reset values
  localparam logic [7:0] GAMMA_CTRL_RST = 8'h00;
  localparam logic [5:0] GAMMA_INDEX_RST = 6'h00;
  localparam logic [7:0] POWER_SAVE_RST = 8'h00;
  localparam logic [2:0] SYNC_CTRL_RST = 3'h0;
  // gamma table geometry
  localparam int GAMMA_DEPTH = 64;
  localparam int GAMMA_AW = 6;
  localparam int GAMMA_OUT_W = 6;
  localparam logic [5:0] GAMMA_INDEX_STEP = 6'h01;
  // gamma control fields
  localparam int GAMMA_EN_BIT = 0;
  localparam int GAMMA_MODE_LSB = 1;
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_RED = 2'h1;
  localparam logic [1:0] MODE_GREEN = 2'h2;
  localparam logic [1:0] MODE_BLUE = 2'h3;
  // power-save fields
  localparam int PS_PIN_FUNC_BIT = 7;
  localparam int PS_SLEEP_BIT = 1;
  localparam int PS_STANDBY_BIT = 0;
  // blanking status fields
  localparam int BS_VACT_BIT = 7;
  localparam int BS_HACT_BIT = 6;
  localparam int BS_ACT_BIT = 5;
  localparam int BS_SYNC_EN_BIT = 2;
  localparam int BS_SEL_LSB = 0;
  // frame-sync pin sources
  localparam logic [1:0] SYNC_SEL_RSVD = 2'h0;
  localparam logic [1:0] SYNC_SEL_HBLANK = 2'h1;
  localparam logic [1:0] SYNC_SEL_VBLANK = 2'h2;
  localparam logic [1:0] SYNC_SEL_SYNCS = 2'h3;
  // pll settling after sleep exit
  localparam longint CLK_PERIOD_PS = 8000;
  localparam longint PLL_SETTLE_MS = 10;
  localparam longint PLL_SETTLE_CYC = (PLL_SETTLE_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 21;
endpackage : lcd_regs_pkg

// ===== testbench/host_bus_model.sv
// host model: parallel-bus master issuing register index and data cycles
// assumes the device samples the strobes on rising clk_sys_i edges
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_sys_i, // system clock
  input wire logic [7:0] rdata_i, // device read data
  output logic cs_b_o, // chip select, active low
  output logic rs_o, // 0 index, 1 data
  output logic wr_b_o, // write strobe, active low
  output logic rd_b_o, // read strobe, active low
  output logic [7:0] wdata_o // write data
);
  import lcd_regs_pkg::*;
  logic [7:0] idx; // last index written
  // idle bus from time zero
  initial begin
    cs_b_o = 1'b1;
    rs_o = 1'b0;
    wr_b_o = 1'b1;
    rd_b_o = 1'b1;
    wdata_o = 8'h00;
    idx = 8'h00;
  end
  // one write; held a full cycle, then released so the strobe is seen high again
  task automatic wr(input logic rs, input logic [7:0] d);
    if (rs && idx == BLANK_STATUS_OFS) begin
      d[4] = 1'b0;
      if (d[1:0] == SYNC_SEL_RSVD) d[1:0] = SYNC_SEL_HBLANK;
    end
    if (!rs) idx = d;
    @(negedge clk_sys_i);
    cs_b_o = 1'b0;
    rs_o = rs;
    wdata_o = d;
    wr_b_o = 1'b0;
    @(negedge clk_sys_i);
    cs_b_o = 1'b1;
    wr_b_o = 1'b1;
    wdata_o = ~d; // a released bus keeps no stale value
  endtask : wr
  // one read; data taken after the registered read latency
  task automatic rd(input logic rs, output logic [7:0] d);
    @(negedge clk_sys_i);
    cs_b_o = 1'b0;
    rs_o = rs;
    rd_b_o = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    d = rdata_i;
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
  endtask : rd
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    wr(1'b0, ofs);
    wr(1'b1, d);
  endtask : wreg
  task automatic rreg(input logic [7:0] ofs, output logic [7:0] d);
    wr(1'b0, ofs);
    rd(1'b1, d);
  endtask : rreg
  // a load always covers every entry from index zero
  task automatic load_table(input logic [5:0] mask);
    wreg(GAMMA_INDEX_OFS, 8'h00);
    wr(1'b0, GAMMA_DATA_OFS);
    for (int i = 0; i < GAMMA_DEPTH; i++) begin
      wr(1'b1, {2'b11, i[5:0] ^ mask});
    end
  endtask : load_table
endmodule : host_bus_model

// ===== testbench/lcd_blank_status_gamma_power_bench.sv
// bench: register block driven by the host model, timing pins by the bench
// assumes a 125 MHz clock and a settle count shortened to 20 cycles
`timescale 1ns/1ps
module lcd_blank_status_gamma_power_bench;
  import lcd_regs_pkg::*;
  logic clk_sys_i, rst_b_i, cs_b_i, rs_i, wr_b_i, rd_b_i, data_oe_o, frame_sync_output_pin_o, fmt_565_i;
  logic horizontal_active_interval_i, vertical_active_interval_i, hsync_i, vsync_i, power_save_input_pin_i;
  logic pll_stop_o, blocks_stop_o, mem_ready_o;
  logic [7:0] data_i, data_o, v;
  logic [5:0] pix_r_i, pix_g_i, pix_b_i, out_r_o, out_g_o, out_b_o, x;
  int failures = 0;
  int n_compared = 0;
  lcd_blank_status_gamma_power #(.SETTLE_CYCLES(20)) i_lcd_blank_status_gamma_power (.clk_sys_i, .rst_b_i,
    .cs_b_i, .rs_i, .wr_b_i, .rd_b_i, .data_i, .data_o, .data_oe_o, .horizontal_active_interval_i,
    .vertical_active_interval_i, .hsync_i, .vsync_i, .frame_sync_output_pin_o, .pix_r_i, .pix_g_i, .pix_b_i,
    .fmt_565_i, .out_r_o, .out_g_o, .out_b_o, .power_save_input_pin_i, .pll_stop_o, .blocks_stop_o, .mem_ready_o);
  host_bus_model i_host_bus_model (.clk_sys_i, .rdata_i(data_o), .cs_b_o(cs_b_i), .rs_o(rs_i), .wr_b_o(wr_b_i),
    .rd_b_o(rd_b_i), .wdata_o(data_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick
  // status bits over all interval combinations; the first read is the reset state
  task automatic t_status;
    for (int k = 0; k < 4; k++) begin
      {vertical_active_interval_i, horizontal_active_interval_i} = k[1:0];
      // bus drive enable looked at while the read strobe is held low, then after release
      fork
        i_host_bus_model.rreg(BLANK_STATUS_OFS, v);
        begin
          tick(4);
          chk({7'h0, data_oe_o}, 8'h01);
        end
      join
      chk(v, {k[1], k[0], k[1] & k[0], 5'h00});
      chk({7'h0, frame_sync_output_pin_o}, 8'h00);
      tick(1);
      chk({7'h0, data_oe_o}, 8'h00);
    end
  endtask : t_status
  // each enable and source against every level combination
  task automatic t_sync;
    logic [2:0] cfg [4] = '{3'h5, 3'h6, 3'h7, 3'h3};
    logic e;
    for (int c = 0; c < 4; c++) begin
      i_host_bus_model.wreg(BLANK_STATUS_OFS, {5'h1f, cfg[c]});
      i_host_bus_model.rreg(BLANK_STATUS_OFS, v);
      chk(v, {5'h1c, cfg[c]});
      for (int k = 0; k < 16; k++) begin
        {vsync_i, hsync_i, vertical_active_interval_i, horizontal_active_interval_i} = k[3:0];
        tick(2);
        case (cfg[c][1:0])
          2'h1: e = !k[0];
          2'h2: e = !k[1];
          default: e = k[2] | k[3];
        endcase
        chk({7'h0, frame_sync_output_pin_o}, {7'h0, e & cfg[c][2]});
      end
    end
  endtask : t_sync
  // one table load, then every code looked up, plain and 5:6:5
  task automatic t_gamma;
    i_host_bus_model.wreg(GAMMA_CTRL_OFS, 8'h01);
    i_host_bus_model.load_table(6'h2a);
    for (int m = 0; m < 128; m++) begin
      fmt_565_i = m[6];
      {pix_r_i, pix_g_i, pix_b_i} = {3{m[5:0]}};
      x = m[6] ? {1'b0, m[4:0]} : m[5:0];
      tick(2);
      chk({2'h0, out_g_o}, {2'h0, m[5:0] ^ 6'h2a});
      chk({2'h0, out_r_o}, {2'h0, x ^ 6'h2a});
      chk({2'h0, out_b_o}, {2'h0, x ^ 6'h2a});
    end
    // a full load wraps the index to zero; the top bits stay in the table
    i_host_bus_model.rreg(GAMMA_INDEX_OFS, v);
    chk(v, 8'h00);
    i_host_bus_model.rreg(GAMMA_DATA_OFS, v);
    chk(v, 8'hea);
    // single green-only write: only that table moves, index steps once
    i_host_bus_model.wreg(GAMMA_CTRL_OFS, 8'h05);
    i_host_bus_model.wreg(GAMMA_INDEX_OFS, 8'h05);
    i_host_bus_model.wreg(GAMMA_DATA_OFS, 8'h3c);
    i_host_bus_model.rreg(GAMMA_INDEX_OFS, v);
    chk(v, 8'h06);
    fmt_565_i = 1'b0;
    {pix_r_i, pix_g_i, pix_b_i} = {3{6'h05}};
    tick(2);
    chk({2'h0, out_r_o}, 8'h2f);
    chk({2'h0, out_g_o}, 8'h3c);
    chk({2'h0, out_b_o}, 8'h2f);
    // bypass: 5-bit red and blue widened by copying their msb
    i_host_bus_model.wreg(GAMMA_CTRL_OFS, 8'h00);
    fmt_565_i = 1'b1;
    {pix_r_i, pix_g_i, pix_b_i} = {3{6'h13}};
    tick(2);
    chk({2'h0, out_r_o}, 8'h27);
    chk({2'h0, out_g_o}, 8'h13);
    chk({2'h0, out_b_o}, 8'h27);
  endtask : t_gamma
  function automatic logic [7:0] pw();
    return {5'h0, pll_stop_o, blocks_stop_o, mem_ready_o};
  endfunction : pw
  // sleep with settle, standby with prompt return, pin in both routings
  task automatic t_power;
    i_host_bus_model.wreg(POWER_SAVE_OFS, 8'h02);
    tick(2);
    chk(pw(), 8'h06);
    i_host_bus_model.wreg(POWER_SAVE_OFS, 8'h00);
    tick(10);
    chk(pw(), 8'h00);
    tick(15);
    chk(pw(), 8'h01);
    i_host_bus_model.wreg(POWER_SAVE_OFS, 8'h01);
    tick(2);
    chk(pw(), 8'h02);
    i_host_bus_model.wreg(POWER_SAVE_OFS, 8'h00);
    tick(3);
    chk(pw(), 8'h01);
    power_save_input_pin_i = 1'b1;
    tick(2);
    chk(pw(), 8'h06);
    power_save_input_pin_i = 1'b0;
    tick(25);
    i_host_bus_model.wreg(POWER_SAVE_OFS, 8'h80);
    power_save_input_pin_i = 1'b1;
    tick(2);
    chk(pw(), 8'h02);
    power_save_input_pin_i = 1'b0;
  endtask : t_power
  task automatic complete_run;
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // watchdog: the run needs only about 700 cycles
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  // reset for two cycles, then the scenarios in turn
  initial begin
    rst_b_i = 1'b0;
    {horizontal_active_interval_i, vertical_active_interval_i, hsync_i, vsync_i} = 4'h0;
    {fmt_565_i, power_save_input_pin_i, pix_r_i, pix_g_i, pix_b_i} = 20'h00000;
    tick(2);
    rst_b_i = 1'b1;
    t_status();
    t_sync();
    t_gamma();
    t_power();
    complete_run();
  end
endmodule : lcd_blank_status_gamma_power_bench

// ===== testbench/lcd_blank_status_gamma_power_sva.sv
// checker: power, reset and frame-sync relations at the block's ports
// assumes it is bound into the block and sees only its ports
`timescale 1ns/1ps
module lcd_blank_status_gamma_power_sva (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_b_i, // reset, active low
  input wire logic data_oe_o, // bus drive enable
  input wire logic horizontal_active_interval_i, // line active
  input wire logic vertical_active_interval_i, // frame active
  input wire logic hsync_i, // horizontal sync
  input wire logic vsync_i, // vertical sync
  input wire logic frame_sync_output_pin_o, // frame-sync pin
  input wire logic power_save_input_pin_i, // power-save pin
  input wire logic pll_stop_o, // pll stopped
  input wire logic blocks_stop_o, // blocks stopped
  input wire logic mem_ready_o // memory ready
);
  // a high pin needs some blanking or sync source behind it, whatever the select
  logic any_src;
  assign any_src = !horizontal_active_interval_i || !vertical_active_interval_i || hsync_i || vsync_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  pll_with_blocks_a: assert property (pll_stop_o |-> blocks_stop_o)
    else $error("pll stopped alone");
  stop_blocks_mem_a: assert property (blocks_stop_o |-> !mem_ready_o)
    else $error("memory ready while stopped");
  sleep_settle_a: assert property ($fell(pll_stop_o) |-> !mem_ready_o [*8])
    else $error("memory ready before pll settle");
  standby_quick_a: assert property ($fell(blocks_stop_o) && !$past(pll_stop_o) && !power_save_input_pin_i
    |-> ##[0:2] mem_ready_o)
    else $error("memory late after standby");
  pin_request_a: assert property (power_save_input_pin_i ##1 power_save_input_pin_i |-> blocks_stop_o)
    else $error("power-save pin ignored");
  sync_source_a: assert property (frame_sync_output_pin_o |-> $past(any_src))
    else $error("frame sync without source");
  reset_quiet_a: assert property ($rose(rst_b_i) |-> !frame_sync_output_pin_o && !pll_stop_o && !data_oe_o)
    else $error("output active out of reset");
  reset_ready_a: assert property ($rose(rst_b_i) && !power_save_input_pin_i |-> !mem_ready_o ##1 mem_ready_o)
    else $error("memory ready timing after reset");
endmodule : lcd_blank_status_gamma_power_sva

bind lcd_blank_status_gamma_power lcd_blank_status_gamma_power_sva i_lcd_blank_status_gamma_power_sva (
  .clk_sys_i, .rst_b_i, .data_oe_o, .horizontal_active_interval_i, .vertical_active_interval_i, .hsync_i,
  .vsync_i, .frame_sync_output_pin_o, .power_save_input_pin_i, .pll_stop_o, .blocks_stop_o, .mem_ready_o);
